// *** hdl/rsj_bit_if.sv ***
// Bundle between the executor and the bit-addressable store.
// Assumes both ends sit on mclk.
`timescale 1ns/10ps
interface rsj_bit_if;
  logic       wr_en;    // Set the addressed bit this edge
  logic [7:0] wr_addr;  // Bit address to set
  logic [7:0] rd_addr;  // Bit address to read
  logic       rd_data;  // Registered read data

  modport exec  (output wr_en, output wr_addr, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input rd_addr, output rd_data);
endinterface

// *** hdl/rsj_bit_store.sv ***
// Bit-addressable storage, 256 single-bit cells addressed by bit address.
// Assumes writes only ever set a bit; clears come from reset.
`timescale 1ns/10ps
module rsj_bit_store
  import rsj_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  rsj_bit_if.store  bus
);

  // ==========================================================
  // Cell array
  logic [255:0] bits_q;  // Cell contents
  logic [255:0] bits_d;  // Next cell contents
  logic         rd_d;    // Next read value

  // One cell per bit address; only the addressed cell can be set
  for (genvar i = 0; i < 256; i++) begin : g_cell
    always_comb begin
      bits_d[i] = bits_q[i] | (bus.wr_en && (bus.wr_addr == 8'(i)));
    end
  end

  // Read port, registered so the top output comes from a flop
  always_comb begin
    rd_d = bits_q[bus.rd_addr];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bits_q      <= {256{RSJ_BIT_RST}};
      bus.rd_data <= RSJ_BIT_RST;
    end else begin
      bits_q      <= bits_d;
      bus.rd_data <= rd_d;
    end
  end

  // A set request leaves the addressed cell at one after the next edge
  property p_bit_set;
    @(posedge mclk) disable iff (rst)
    bus.wr_en |=> bits_q[$past(bus.wr_addr)];
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("addressed bit not set");

endmodule

// *** hdl/rsj_exec.sv ***
// Executor for rotate right, rotate right through carry, set bit and short jump.
// Assumes the core presents one opcode plus its second byte per request, synchronous to mclk.
`timescale 1ns/10ps
module rsj_exec
  import rsj_pkg::*;
(
  input  wire logic        mclk,            // Machine-cycle clock
  input  wire logic        rst,             // Synchronous reset, active high
  input  wire logic        instr_valid,     // Instruction offered
  input  wire logic [7:0]  instr_opcode,    // First instruction byte
  input  wire logic [7:0]  instr_operand,   // Second byte, when the form has one
  input  wire logic        load_en,         // Core loads state this cycle, unless a short jump is in its second cycle
  input  wire logic [7:0]  load_acc,        // Accumulator to load
  input  wire logic        load_carry,      // Carry to load
  input  wire logic [15:0] load_pc,         // Program counter to load
  input  wire logic [7:0]  bit_rd_addr,     // Bit address to observe
  output logic             instr_ready,     // Ready to take an instruction
  output logic             instr_done,      // Pulse: instruction retired
  output logic             instr_unknown,   // Pulse: opcode not handled here
  output logic [7:0]       acc,             // Accumulator
  output logic             carry,           // Carry flag
  output logic [15:0]      pc,              // Program counter
  output logic             bit_rd_data      // Registered bit read data
);

  // ==========================================================
  // State
  rsj_state_t  state_q, state_d;      // Sequencer
  logic [7:0]  acc_q, acc_d;          // Accumulator
  logic        carry_q, carry_d;      // Carry flag
  logic [15:0] pc_q, pc_d;            // Program counter
  logic [7:0]  rel_q, rel_d;          // Held jump displacement
  logic [15:0] origin_q, origin_d;    // Address of the jump in flight
  logic        ready_q, ready_d;      // Registered ready
  logic        done_q, done_d;        // Retire pulse
  logic        unknown_q, unknown_d;  // Unknown opcode pulse
  logic        take;                  // Instruction accepted this edge

  rsj_bit_if bit_bus ();  // Path to the bit store

  // ==========================================================
  // Bit store
  rsj_bit_store u_store (
    .mclk (mclk),
    .rst  (rst),
    .bus  (bit_bus)
  );

  // Load wins over an instruction offered in the same cycle; the instruction is dropped
  assign take = instr_valid && ready_q && !load_en;

  // Set-bit path to storage, decoded straight from the accepted opcode
  always_comb begin
    bit_bus.wr_en   = take && (instr_opcode == RSJ_OP_SET_BIT);
    bit_bus.wr_addr = instr_operand;
    bit_bus.rd_addr = bit_rd_addr;
  end

  // ==========================================================
  // Decode and execute
  // Each case computes the whole next machine state in one pass
  always_comb begin
    state_d   = state_q;
    acc_d     = acc_q;
    carry_d   = carry_q;
    pc_d      = pc_q;
    rel_d     = rel_q;
    origin_d  = origin_q;
    done_d    = 1'b0;
    unknown_d = 1'b0;
    unique case (state_q)
      RSJ_ST_IDLE: begin
        if (load_en) begin
          // Core overwrites the working state
          acc_d   = load_acc;
          carry_d = load_carry;
          pc_d    = load_pc;
        end else if (take) begin
          unique case (instr_opcode)
            RSJ_OP_ROTATE_RIGHT: begin
              // Carry untouched
              acc_d  = {acc_q[0], acc_q[7:1]};
              pc_d   = pc_q + RSJ_LEN_ONE_BYTE;
              done_d = 1'b1;
            end
            RSJ_OP_ROTATE_RIGHT_C: begin
              // Old carry enters bit 7, bit 0 leaves into carry
              acc_d   = {carry_q, acc_q[7:1]};
              carry_d = acc_q[0];
              pc_d    = pc_q + RSJ_LEN_ONE_BYTE;
              done_d  = 1'b1;
            end
            RSJ_OP_SET_CARRY: begin
              carry_d = 1'b1;
              pc_d    = pc_q + RSJ_LEN_ONE_BYTE;
              done_d  = 1'b1;
            end
            RSJ_OP_SET_BIT: begin
              // Storage write goes out on the bit bus; flags stay
              pc_d   = pc_q + RSJ_LEN_TWO_BYTE;
              done_d = 1'b1;
            end
            RSJ_OP_SHORT_JUMP: begin
              // First cycle steps past both bytes, keeps the displacement
              pc_d     = pc_q + RSJ_LEN_TWO_BYTE;
              rel_d    = instr_operand;
              origin_d = pc_q;
              state_d  = RSJ_ST_JUMP;
            end
            default: begin
              // Not ours: leave all state, flag it for the core
              unknown_d = 1'b1;
            end
          endcase
        end
      end
      RSJ_ST_JUMP: begin
        // Sign extension bounds the reach to -128..+127 from the next instruction
        pc_d    = pc_q + {{8{rel_q[7]}}, rel_q};
        done_d  = 1'b1;
        state_d = RSJ_ST_IDLE;
      end
    endcase
    // Ready drops for the second jump cycle only
    ready_d = (state_d == RSJ_ST_IDLE);
  end

  // Register the whole machine state
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q   <= RSJ_ST_IDLE;
      acc_q     <= RSJ_ACC_RST;
      carry_q   <= RSJ_CARRY_RST;
      pc_q      <= RSJ_PC_RST;
      rel_q     <= 8'h00;
      origin_q  <= RSJ_PC_RST;
      ready_q   <= 1'b1;
      done_q    <= 1'b0;
      unknown_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      acc_q     <= acc_d;
      carry_q   <= carry_d;
      pc_q      <= pc_d;
      rel_q     <= rel_d;
      origin_q  <= origin_d;
      ready_q   <= ready_d;
      done_q    <= done_d;
      unknown_q <= unknown_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign instr_ready   = ready_q;
  assign instr_done    = done_q;
  assign instr_unknown = unknown_q;
  assign acc           = acc_q;
  assign carry         = carry_q;
  assign pc            = pc_q;
  assign bit_rd_data   = bit_bus.rd_data;

  // ==========================================================
  // Checks
  logic [15:0] jump_span;  // Target minus jump address
  assign jump_span = pc_q - origin_q;

  property p_rot_data;
    @(posedge mclk) disable iff (rst)
    take && instr_opcode == RSJ_OP_ROTATE_RIGHT
      |=> acc_q == {$past(acc_q[0]), $past(acc_q[7:1])} && carry_q == $past(carry_q);
  endproperty
  a_rot_data: assert property (p_rot_data) else $error("rotate right result wrong");

  property p_rot_timing;
    @(posedge mclk) disable iff (rst)
    take && instr_opcode == RSJ_OP_ROTATE_RIGHT |=> done_q && ready_q && pc_q == $past(pc_q) + 16'h0001;
  endproperty
  a_rot_timing: assert property (p_rot_timing) else $error("rotate right not one byte one cycle");

  property p_rotc_data;
    @(posedge mclk) disable iff (rst)
    take && instr_opcode == RSJ_OP_ROTATE_RIGHT_C
      |=> acc_q == {$past(carry_q), $past(acc_q[7:1])} && carry_q == $past(acc_q[0]);
  endproperty
  a_rotc_data: assert property (p_rotc_data) else $error("rotate through carry wrong");

  property p_rotc_timing;
    @(posedge mclk) disable iff (rst)
    take && instr_opcode == RSJ_OP_ROTATE_RIGHT_C |=> done_q ##0 pc_q == $past(pc_q) + 16'h0001;
  endproperty
  a_rotc_timing: assert property (p_rotc_timing) else $error("rotate through carry timing wrong");

  property p_setc;
    @(posedge mclk) disable iff (rst)
    take && instr_opcode == RSJ_OP_SET_CARRY |=> carry_q && acc_q == $past(acc_q) && done_q;
  endproperty
  a_setc: assert property (p_setc) else $error("set carry wrong");

  property p_set_addr_bit;
    @(posedge mclk) disable iff (rst)
    take && instr_opcode == RSJ_OP_SET_BIT
      |=> carry_q == $past(carry_q) && done_q && pc_q == $past(pc_q) + 16'h0002;
  endproperty
  a_set_addr_bit: assert property (p_set_addr_bit) else $error("set bit changed flag or length");

  // Displacement taken from the offered byte, so a bad capture into the holding register shows up
  property p_jump_target;
    @(posedge mclk) disable iff (rst)
    take && instr_opcode == RSJ_OP_SHORT_JUMP
      |=> pc_q == $past(pc_q) + 16'h0002
      ##1 pc_q == $past(pc_q) + {{8{$past(instr_operand[7], 2)}}, $past(instr_operand, 2)};
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("short jump target wrong");

  property p_jump_range;
    @(posedge mclk) disable iff (rst)
    state_q == RSJ_ST_JUMP
      |=> (jump_span + RSJ_JUMP_BACK_MAX - 16'h0002) <= (RSJ_JUMP_BACK_MAX + RSJ_JUMP_FWD_MAX);
  endproperty
  a_jump_range: assert property (p_jump_range) else $error("short jump out of reach");

  property p_jump_cycles;
    @(posedge mclk) disable iff (rst)
    take && instr_opcode == RSJ_OP_SHORT_JUMP |=> !done_q && !ready_q ##1 done_q && ready_q;
  endproperty
  a_jump_cycles: assert property (p_jump_cycles) else $error("short jump not two cycles");

endmodule

// *** hdl/rsj_pkg.sv ***
// Constants and types for the rotate / set-bit / short-jump execution block.
// Assumes one machine cycle per mclk edge; the core feeds one instruction at a time.
package rsj_pkg;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] RSJ_OP_ROTATE_RIGHT  = 8'h03;  // Rotate right, 1 byte
  localparam logic [7:0] RSJ_OP_ROTATE_RIGHT_C = 8'h13; // Rotate right through carry
  localparam logic [7:0] RSJ_OP_SET_CARRY     = 8'hD3;  // Set carry flag
  localparam logic [7:0] RSJ_OP_SET_BIT       = 8'hD2;  // Set addressed bit
  localparam logic [7:0] RSJ_OP_SHORT_JUMP    = 8'h80;  // Short relative jump

  // ==========================================================
  // Instruction lengths, added to the program counter
  localparam logic [15:0] RSJ_LEN_ONE_BYTE = 16'h0001;  // One-byte forms
  localparam logic [15:0] RSJ_LEN_TWO_BYTE = 16'h0002;  // Two-byte forms

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RSJ_ACC_RST   = 8'h00;        // Accumulator
  localparam logic        RSJ_CARRY_RST = 1'b0;         // Carry flag
  localparam logic [15:0] RSJ_PC_RST    = 16'h0000;     // Program counter
  localparam logic        RSJ_BIT_RST   = 1'b0;         // Bit-addressable cells

  // ==========================================================
  // Displacement reach from the next instruction
  localparam logic [15:0] RSJ_JUMP_BACK_MAX = 16'h0080;  // 128 bytes before
  localparam logic [15:0] RSJ_JUMP_FWD_MAX  = 16'h007F;  // 127 bytes after

  // Sequencer states
  typedef enum logic [0:0] {
    RSJ_ST_IDLE = 1'b0,  // Ready for an instruction
    RSJ_ST_JUMP = 1'b1   // Second machine cycle of a short jump
  } rsj_state_t;

endpackage

// *** verification/rotate_setbit_shortjump_exec_tb.sv ***
// Self-checking bench for the rotate / set-bit / short-jump executor.
// Assumes rsj_pkg and rsj_exec are compiled first; inputs move on falling edges.
`timescale 1ns/10ps
module rotate_setbit_shortjump_exec_tb;
  import rsj_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic        mclk = 1'b0;            // 25 MHz clock
  logic        rst = 1'b1;             // Synchronous reset
  logic        instr_valid = 1'b0;     // Instruction offered
  logic [7:0]  instr_opcode = 8'h00;   // First byte
  logic [7:0]  instr_operand = 8'h00;  // Second byte
  logic        load_en = 1'b0;         // State load strobe
  logic [7:0]  load_acc = 8'h00;       // Loaded accumulator
  logic        load_carry = 1'b0;      // Loaded carry
  logic [15:0] load_pc = 16'h0000;     // Loaded program counter
  logic [7:0]  bit_rd_addr = 8'h00;    // Observed bit address
  logic        instr_ready;            // Ready
  logic        instr_done;             // Retire pulse
  logic        instr_unknown;          // Unknown opcode pulse
  logic [7:0]  acc;                    // Accumulator
  logic        carry;                  // Carry flag
  logic [15:0] pc;                     // Program counter
  logic        bit_rd_data;            // Bit read data
  // Reference state, kept by the bench alone
  logic [7:0]  m_acc;
  logic        m_c;
  logic [15:0] m_pc;
  logic        m_bits [256];
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [7:0]  ops [6];                // Opcode table for random draws

  always #20 mclk = ~mclk;

  rsj_exec DUT (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .instr_operand(instr_operand), .load_en(load_en), .load_acc(load_acc), .load_carry(load_carry),
    .load_pc(load_pc), .bit_rd_addr(bit_rd_addr), .instr_ready(instr_ready), .instr_done(instr_done),
    .instr_unknown(instr_unknown), .acc(acc), .carry(carry), .pc(pc), .bit_rd_data(bit_rd_data));

  // ==========================================================
  // Helpers
  // Flags and accumulator packed for one compare
  function automatic logic [15:0] st();
    return {4'h0, instr_ready, instr_done, instr_unknown, carry, acc};
  endfunction
  // Target of a short jump; 16-bit wrap is intended
  function automatic logic [15:0] exp_jump(input logic [15:0] p, input logic [7:0] r);
    return p + RSJ_LEN_TWO_BYTE + {{8{r[7]}}, r};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Load state; a clashing instruction is offered too, since load must win
  task automatic load(input logic [7:0] a, input logic c, input logic [15:0] p);
    load_en      = 1'b1;
    load_acc     = a;
    load_carry   = c;
    load_pc      = p;
    instr_valid  = 1'b1;
    instr_opcode = RSJ_OP_SET_CARRY;
    @(negedge mclk);
    load_en = 1'b0;
    instr_valid = 1'b0;
    m_acc = a;
    m_c   = c;
    m_pc  = p;
    check(st(), {4'h0, 1'b1, 1'b0, 1'b0, m_c, m_acc});
    check(pc, m_pc);
  endtask
  // Offer one instruction; gap=0 leaves valid up so the next call goes back to back
  task automatic issue(input logic [7:0] op, input logic [7:0] opr, input bit gap);
    logic [15:0] pc0;
    logic [7:0]  a0;
    logic        known;
    pc0 = m_pc;
    a0 = m_acc;
    known = 1'b1;
    instr_valid   = 1'b1;
    instr_opcode  = op;
    instr_operand = opr;
    bit_rd_addr = (op == RSJ_OP_SET_BIT) ? opr : 8'($urandom);
    case (op)
      RSJ_OP_ROTATE_RIGHT: begin
        m_acc = {a0[0], a0[7:1]};
        m_pc  = pc0 + RSJ_LEN_ONE_BYTE;
      end
      RSJ_OP_ROTATE_RIGHT_C: begin
        m_acc = {m_c, a0[7:1]};
        m_c   = a0[0];
        m_pc  = pc0 + RSJ_LEN_ONE_BYTE;
      end
      RSJ_OP_SET_CARRY: begin
        m_c  = 1'b1;
        m_pc = pc0 + RSJ_LEN_ONE_BYTE;
      end
      RSJ_OP_SET_BIT: begin
        m_bits[opr] = 1'b1;
        m_pc        = pc0 + RSJ_LEN_TWO_BYTE;
      end
      RSJ_OP_SHORT_JUMP: m_pc = exp_jump(pc0, opr);
      default: known = 1'b0;  // No state change expected
    endcase
    @(negedge mclk);
    if (op == RSJ_OP_SHORT_JUMP) begin
      // Valid stays high here on purpose: it must be refused
      check(st(), {4'h0, 1'b0, 1'b0, 1'b0, m_c, m_acc});
      check(pc, pc0 + RSJ_LEN_TWO_BYTE);
      @(negedge mclk);
    end
    check(st(), {4'h0, 1'b1, known, !known, m_c, m_acc});
    check(pc, m_pc);
    if (gap) begin
      instr_valid = 1'b0;
      @(negedge mclk);
      check(16'(bit_rd_data), 16'(m_bits[bit_rd_addr]));
      check(16'(instr_done), 16'h0000);
    end
  endtask
  task automatic reset_model();
    for (int i = 0; i < 256; i++) m_bits[i] = RSJ_BIT_RST;
    m_acc = RSJ_ACC_RST;
    m_c   = RSJ_CARRY_RST;
    m_pc  = RSJ_PC_RST;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hBCDBAD25));
    ops = '{RSJ_OP_ROTATE_RIGHT, RSJ_OP_ROTATE_RIGHT_C, RSJ_OP_SET_CARRY, RSJ_OP_SET_BIT,
            RSJ_OP_SHORT_JUMP, 8'hA5};
    reset_model();
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    check(st(), {4'h0, 1'b1, 1'b0, 1'b0, m_c, m_acc});
    check(pc, m_pc);
    $display("test reset done");
    // Worked values and displacement extremes
    load(8'hC5, 1'b0, 16'h0100);
    issue(RSJ_OP_ROTATE_RIGHT, 8'h00, 1'b1);
    load(8'hC5, 1'b0, 16'h0100);
    issue(RSJ_OP_ROTATE_RIGHT_C, 8'h00, 1'b1);
    // Jump sitting at 0100 with displacement 21 lands on 0123
    load(8'h62, 1'b1, 16'h0100);
    issue(RSJ_OP_SHORT_JUMP, 8'h21, 1'b1);
    foreach (ops[i]) issue(RSJ_OP_SHORT_JUMP, (i % 2) ? 8'h80 : 8'h7F, 1'b0);
    issue(RSJ_OP_SHORT_JUMP, 8'hFE, 1'b1);
    load(8'h3C, 1'b1, 16'hFFFF);
    issue(RSJ_OP_SHORT_JUMP, 8'h7F, 1'b1);
    $display("test corners done");
    // Back to back through the whole opcode table, short jump and unknown opcode included
    foreach (ops[i]) issue(ops[i], 8'(i), 1'b0);
    issue(RSJ_OP_SET_BIT, 8'hFF, 1'b1);
    $display("test back to back done");
    // Random traffic with occasional loads
    repeat (300) begin
      if ($urandom_range(0, 7) == 0) load(8'($urandom), 1'($urandom), 16'($urandom));
      issue(ops[$urandom_range(0, 5)], 8'($urandom), 1'($urandom));
    end
    issue(RSJ_OP_SET_CARRY, 8'h00, 1'b1);
    $display("test random done");
    // Reset in mid-run clears state and bit cells
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    reset_model();
    check(st(), {4'h0, 1'b1, 1'b0, 1'b0, m_c, m_acc});
    check(pc, m_pc);
    issue(RSJ_OP_ROTATE_RIGHT, 8'h00, 1'b1);
    $display("test second reset done");
    conclude();
  end

  // Watchdog, well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    conclude();
  end
endmodule
